// ---- ttp_pkg.sv ----
// shared constants for the thermal trip point control block
package ttp_pkg;
	// register dword addresses (byte address bits 11:2) and byte lanes
	localparam logic [11:0] TRIP_ADDR = 12'hcdc;
	localparam logic [11:0] CAL_ADDR = 12'hce2;
	localparam logic [11:0] THR_ADDR = 12'hce4;
	localparam logic [11:0] FUSE_ADDR = 12'hce6;
	localparam logic [11:0] STAT_ADDR = 12'hcea;
	localparam logic [11:0] AUXLOCK_ADDR = 12'hcec;
	localparam logic [11:0] KEYALT_ADDR = 12'hc9c;
	localparam logic [9:0] TRIP_DW = TRIP_ADDR[11:2];
	localparam logic [9:0] CAL_DW = CAL_ADDR[11:2];
	localparam logic [9:0] THR_DW = THR_ADDR[11:2];
	localparam logic [9:0] STAT_DW = STAT_ADDR[11:2];
	localparam logic [9:0] AUXLOCK_DW = AUXLOCK_ADDR[11:2];
	localparam logic [9:0] KEYALT_DW = KEYALT_ADDR[11:2];
	localparam logic [1:0] CAL_LANE = CAL_ADDR[1:0];
	localparam logic [1:0] THR_LANE = THR_ADDR[1:0];
	localparam logic [1:0] FUSE_LANE = FUSE_ADDR[1:0];
	localparam logic [1:0] STAT_LANE = STAT_ADDR[1:0];
	localparam logic [1:0] STAT_LANE_HI = 2'h3;
	localparam logic [1:0] AUX_LANE = 2'h0;
	localparam logic [1:0] AUXLOCK_LANE = 2'h3;
	// field positions
	localparam int RELATIVE_TEMPERATURE_LSB = 24;
	localparam int AUX0_LSB = 16;
	localparam int HOT_LSB = 8;
	localparam int CAT_LSB = 0;
	localparam int CAL_LOCK_BIT = 7;
	localparam int OFFSET_W = 7;
	localparam int DAC_W = 9;
	localparam int THR_EN_BIT = 7;
	localparam int THR_ZONE_BIT = 4;
	localparam int THR_HALT_BIT = 3;
	localparam int THR_LOCK_BIT = 0;
	localparam int SEM_BIT = 7;
	localparam int AUXLOCK_BIT = 7;
	localparam int ST_CAT_RISE = 4;
	localparam int ST_HOT_RISE = 3;
	localparam int ST_AUX0_RISE = 2;
	localparam int ST_AUX1_RISE = 1;
	localparam int ST_CAT_FALL = 9;
	localparam int ST_HOT_FALL = 8;
	localparam int ST_AUX0_FALL = 7;
	localparam int ST_AUX1_FALL = 6;
	localparam logic [15:0] STAT_MASK = 16'h03de;
	localparam logic [31:0] UNLOCK_KEY = 32'h04c1c202;
	localparam logic [3:0] ALL_LANES = 4'hf;
	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam logic [DAC_W-1:0] DAC_RST = 9'h000;
	localparam logic [OFFSET_W-1:0] OFFSET_RST = 7'h00;
	typedef enum logic [1:0] {
		UNLK_IDLE = 2'b00,
		UNLK_ONE = 2'b01,
		UNLK_TWO = 2'b10,
		UNLK_THREE = 2'b11
	} ttp_unlock_e;
endpackage

// ---- ttp_trip_detect.sv ----
// one trip point comparator with rising and falling crossing pulses
`timescale 1ns/10ps
`default_nettype none
module ttp_trip_detect (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] reading, // synchronised thermometer reading
	input wire logic [7:0] setting, // trip point setting
	input wire logic valid, // reading is meaningful
	output logic above, // reading above setting
	output logic risePulse, // one-cycle rising crossing
	output logic fallPulse // one-cycle falling crossing
);
	logic above_reg, above_next;
	logic rise_reg, rise_next;
	logic fall_reg, fall_next;
	logic cmp;

	assign above = above_reg;
	assign risePulse = rise_reg;
	assign fallPulse = fall_reg;

	// invalid readings hold the last state so no false crossing appears
	always_comb begin
		cmp = reading > setting;
		above_next = valid ? cmp : above_reg;
		rise_next = valid & cmp & ~above_reg;
		fall_next = valid & ~cmp & above_reg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			above_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			above_reg <= above_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end
endmodule
`default_nettype wire

// ---- ttp_control_top.sv ----
// thermal trip point control, calibration and trip status registers
//
// Functional notes
// - relative temperature is hot setting minus reading
// - analogue mode returns hot setting as relative
// - aux0 setting writable, frozen by aux lock
// - hot setting frozen by calibration lock
// - catastrophic setting frozen by calibration lock
// - calibration lock sets by one, clears on reset
// - signed offset added to counter for DAC
// - offset sign-extended to nine bits
// - DAC test routes offset straight to bank B
// - master enable gates all hardware actions
// - zone select one throttles hot and catastrophic
// - halt latches trip output until reset
// - fuse semaphore: first read zero, then one
// - fused value read-only, seeds calibration offset
// - rising crossings set status bits 4..1
// - falling crossings set status bits 9..6
// - status sticky, write one clears, reserved zero
// - status identifies which trip raised an event
// - aux lock undone only by key sequence or reset
// - reading is eight-bit binary, valid-qualified
`timescale 1ns/10ps
`default_nettype none
module ttp_control_top (
	input wire logic clk, // 100 MHz core clock
	input wire logic rstn, // async reset, active low
	input wire logic [9:0] regAddr, // dword address, byte address bits 11:2
	input wire logic [3:0] regByteEn, // byte lane enables
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	input wire logic [31:0] regWdata, // write data
	output logic [31:0] regRdata, // read data, registered
	output logic regRdValid, // read data valid pulse
	input wire logic [7:0] sensorReadingPin, // thermometer counter from sensor
	input wire logic sensorValidPin, // thermometer output valid
	input wire logic analogModePin, // sensor in analogue mode
	input wire logic directDacTest, // direct DAC connect test enable
	input wire logic [6:0] fuseValue, // fused calibration value, static
	output logic [8:0] dacBankB, // value to sensor DAC bank B
	output logic thermalTripOutN, // thermal trip out, active low
	output logic throttleRequest, // hardware throttling request
	output logic thermalEventPending // any trip status bit set
);
	logic [7:0] rdSync1_reg, rdSync2_reg;
	logic vldSync1_reg, vldSync2_reg, anaSync1_reg, anaSync2_reg;
	logic [7:0] aux0_reg, aux0_next, hot_reg, hot_next, cat_reg, cat_next;
	logic [7:0] aux1_reg, aux1_next;
	logic calLock_reg, calLock_next, auxLock_reg, auxLock_next;
	logic [6:0] offset_reg, offset_next;
	logic seeded_reg, seeded_next;
	logic thrEn_reg, thrEn_next, thrZone_reg, thrZone_next;
	logic thrHalt_reg, thrHalt_next, thrLock_reg, thrLock_next;
	logic sem_reg, sem_next;
	logic [15:0] status_reg, status_next;
	ttp_pkg::ttp_unlock_e unlk_reg, unlk_next;
	logic [31:0] rdData_reg, rdData_next;
	logic rdValid_reg;
	logic [8:0] dac_reg, dac_next;
	logic tripN_reg, tripN_next, throttle_reg, throttle_next, pending_reg;
	logic wrTrip, wrCal, wrThr, wrStat, wrAux, rdThr, keyLock, keyAlt, unlock;
	logic [7:0] relative_temperature, calByte, thrByte, fuseByte, clrLo, clrHi, auxByte;
	logic [3:0] rise, fall;
	logic [15:0] setBits;

	function automatic logic [7:0] getByte(input logic [31:0] w, input logic [1:0] lane);
		getByte = w[{lane, 3'b000} +: 8];
	endfunction

	function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [1:0] lane);
		mergeByte = regByteEn[lane] ? getByte(regWdata, lane) : old;
	endfunction

	function automatic logic [8:0] signExt(input logic [6:0] v);
		signExt = {{2{v[6]}}, v};
	endfunction

	// pins from the analogue side cross into clk through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdSync1_reg <= ttp_pkg::BYTE_RST;
			rdSync2_reg <= ttp_pkg::BYTE_RST;
			vldSync1_reg <= 1'b0;
			vldSync2_reg <= 1'b0;
			anaSync1_reg <= 1'b0;
			anaSync2_reg <= 1'b0;
		end else begin
			rdSync1_reg <= sensorReadingPin;
			rdSync2_reg <= rdSync1_reg;
			vldSync1_reg <= sensorValidPin;
			vldSync2_reg <= vldSync1_reg;
			anaSync1_reg <= analogModePin;
			anaSync2_reg <= anaSync1_reg;
		end
	end

	// multi-bit reading may tear on a change; the sensor holds it stable between counts
	ttp_trip_detect u_cat (.clk(clk), .rstn(rstn), .reading(rdSync2_reg), .setting(cat_reg),
		.valid(vldSync2_reg), .above(), .risePulse(rise[3]), .fallPulse(fall[3]));
	ttp_trip_detect u_hot (.clk(clk), .rstn(rstn), .reading(rdSync2_reg), .setting(hot_reg),
		.valid(vldSync2_reg), .above(), .risePulse(rise[2]), .fallPulse(fall[2]));
	ttp_trip_detect u_aux0 (.clk(clk), .rstn(rstn), .reading(rdSync2_reg), .setting(aux0_reg),
		.valid(vldSync2_reg), .above(), .risePulse(rise[1]), .fallPulse(fall[1]));
	ttp_trip_detect u_aux1 (.clk(clk), .rstn(rstn), .reading(rdSync2_reg), .setting(aux1_reg),
		.valid(vldSync2_reg), .above(), .risePulse(rise[0]), .fallPulse(fall[0]));

	logic catAbove, hotAbove;
	assign catAbove = vldSync2_reg & (rdSync2_reg > cat_reg);
	assign hotAbove = vldSync2_reg & (rdSync2_reg > hot_reg);

	// access decode
	always_comb begin
		wrTrip = regWrite && (regAddr == ttp_pkg::TRIP_DW);
		wrCal = regWrite && (regAddr == ttp_pkg::CAL_DW) && regByteEn[ttp_pkg::CAL_LANE];
		wrThr = regWrite && (regAddr == ttp_pkg::THR_DW) && regByteEn[ttp_pkg::THR_LANE];
		wrStat = regWrite && (regAddr == ttp_pkg::STAT_DW);
		wrAux = regWrite && (regAddr == ttp_pkg::AUXLOCK_DW);
		rdThr = regRead && (regAddr == ttp_pkg::THR_DW) && regByteEn[ttp_pkg::FUSE_LANE];
		keyLock = wrAux && (regByteEn == ttp_pkg::ALL_LANES) && (regWdata == ttp_pkg::UNLOCK_KEY);
		keyAlt = regWrite && (regAddr == ttp_pkg::KEYALT_DW) &&
			(regByteEn == ttp_pkg::ALL_LANES) && (regWdata == ttp_pkg::UNLOCK_KEY);
	end

	// aux lock unlock sequence; any other access in between restarts it
	always_comb begin
		unlk_next = unlk_reg;
		unlock = 1'b0;
		case (unlk_reg)
			ttp_pkg::UNLK_IDLE: begin
				if (keyLock) unlk_next = ttp_pkg::UNLK_ONE;
			end
			ttp_pkg::UNLK_ONE: begin
				if (keyAlt) unlk_next = ttp_pkg::UNLK_TWO;
				else if (keyLock) unlk_next = ttp_pkg::UNLK_ONE;
				else if (regWrite || regRead) unlk_next = ttp_pkg::UNLK_IDLE;
			end
			ttp_pkg::UNLK_TWO: begin
				if (keyAlt) unlk_next = ttp_pkg::UNLK_THREE;
				else if (keyLock) unlk_next = ttp_pkg::UNLK_ONE;
				else if (regWrite || regRead) unlk_next = ttp_pkg::UNLK_IDLE;
			end
			ttp_pkg::UNLK_THREE: begin
				if (keyLock) begin
					unlock = 1'b1;
					unlk_next = ttp_pkg::UNLK_IDLE;
				end else if (regWrite || regRead) unlk_next = ttp_pkg::UNLK_IDLE;
			end
			default: unlk_next = ttp_pkg::UNLK_IDLE;
		endcase
	end

	// settings, locks and calibration
	always_comb begin
		aux0_next = aux0_reg;
		aux1_next = aux1_reg;
		hot_next = hot_reg;
		cat_next = cat_reg;
		calLock_next = calLock_reg;
		offset_next = offset_reg;
		seeded_next = 1'b1;
		auxLock_next = auxLock_reg;
		if (!seeded_reg) offset_next = fuseValue;
		if (wrTrip && !auxLock_reg) aux0_next = mergeByte(aux0_reg, 2'h2);
		if (wrTrip && !calLock_reg) begin
			hot_next = mergeByte(hot_reg, 2'h1);
			cat_next = mergeByte(cat_reg, 2'h0);
		end
		calByte = getByte(regWdata, ttp_pkg::CAL_LANE);
		if (wrCal && !calLock_reg) offset_next = calByte[ttp_pkg::OFFSET_W-1:0];
		if (wrCal && calByte[ttp_pkg::CAL_LOCK_BIT]) calLock_next = 1'b1;
		if (wrAux && !auxLock_reg) aux1_next = mergeByte(aux1_reg, ttp_pkg::AUX_LANE);
		auxByte = getByte(regWdata, ttp_pkg::AUXLOCK_LANE);
		if (unlock) auxLock_next = 1'b0;
		if (wrAux && regByteEn[ttp_pkg::AUXLOCK_LANE] && auxByte[ttp_pkg::AUXLOCK_BIT])
			auxLock_next = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aux0_reg <= ttp_pkg::BYTE_RST;
			aux1_reg <= ttp_pkg::BYTE_RST;
			hot_reg <= ttp_pkg::BYTE_RST;
			cat_reg <= ttp_pkg::BYTE_RST;
			calLock_reg <= 1'b0;
			offset_reg <= ttp_pkg::OFFSET_RST;
			seeded_reg <= 1'b0;
			auxLock_reg <= 1'b0;
			unlk_reg <= ttp_pkg::UNLK_IDLE;
		end else begin
			aux0_reg <= aux0_next;
			aux1_reg <= aux1_next;
			hot_reg <= hot_next;
			cat_reg <= cat_next;
			calLock_reg <= calLock_next;
			offset_reg <= offset_next;
			seeded_reg <= seeded_next;
			auxLock_reg <= auxLock_next;
			unlk_reg <= unlk_next;
		end
	end

	// throttle control, semaphore and trip status
	always_comb begin
		thrEn_next = thrEn_reg;
		thrZone_next = thrZone_reg;
		thrHalt_next = thrHalt_reg;
		thrLock_next = thrLock_reg;
		thrByte = getByte(regWdata, ttp_pkg::THR_LANE);
		if (wrThr && !thrLock_reg) begin
			thrEn_next = thrByte[ttp_pkg::THR_EN_BIT];
			thrZone_next = thrByte[ttp_pkg::THR_ZONE_BIT];
			thrHalt_next = thrByte[ttp_pkg::THR_HALT_BIT];
		end
		if (wrThr && thrByte[ttp_pkg::THR_LOCK_BIT]) thrLock_next = 1'b1;
		sem_next = sem_reg | rdThr;
		fuseByte = getByte(regWdata, ttp_pkg::FUSE_LANE);
		if (regWrite && (regAddr == ttp_pkg::THR_DW) && regByteEn[ttp_pkg::FUSE_LANE] &&
			fuseByte[ttp_pkg::SEM_BIT]) sem_next = 1'b0;
		clrLo = wrStat ? mergeByte(ttp_pkg::BYTE_RST, ttp_pkg::STAT_LANE) : ttp_pkg::BYTE_RST;
		clrHi = wrStat ? mergeByte(ttp_pkg::BYTE_RST, ttp_pkg::STAT_LANE_HI) : ttp_pkg::BYTE_RST;
		setBits = ttp_pkg::STAT_RST;
		setBits[ttp_pkg::ST_CAT_RISE] = rise[3];
		setBits[ttp_pkg::ST_HOT_RISE] = rise[2];
		setBits[ttp_pkg::ST_AUX0_RISE] = rise[1];
		setBits[ttp_pkg::ST_AUX1_RISE] = rise[0];
		setBits[ttp_pkg::ST_CAT_FALL] = fall[3];
		setBits[ttp_pkg::ST_HOT_FALL] = fall[2];
		setBits[ttp_pkg::ST_AUX0_FALL] = fall[1];
		setBits[ttp_pkg::ST_AUX1_FALL] = fall[0];
		// set wins over a clear in the same cycle so no event is lost
		status_next = ((status_reg & ~{clrHi, clrLo}) | setBits) & ttp_pkg::STAT_MASK;
		throttle_next = thrEn_reg & thrZone_reg & (hotAbove | catAbove);
		tripN_next = tripN_reg & ~(thrEn_reg & thrHalt_reg & catAbove);
		dac_next = directDacTest ? signExt(offset_reg) :
			({1'b0, rdSync2_reg} + signExt(offset_reg));
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			thrEn_reg <= 1'b0;
			thrZone_reg <= 1'b0;
			thrHalt_reg <= 1'b0;
			thrLock_reg <= 1'b0;
			sem_reg <= 1'b0;
			status_reg <= ttp_pkg::STAT_RST;
			throttle_reg <= 1'b0;
			tripN_reg <= 1'b1;
			dac_reg <= ttp_pkg::DAC_RST;
			pending_reg <= 1'b0;
		end else begin
			thrEn_reg <= thrEn_next;
			thrZone_reg <= thrZone_next;
			thrHalt_reg <= thrHalt_next;
			thrLock_reg <= thrLock_next;
			sem_reg <= sem_next;
			status_reg <= status_next;
			throttle_reg <= throttle_next;
			tripN_reg <= tripN_next;
			dac_reg <= dac_next;
			pending_reg <= |status_reg;
		end
	end

	// read path, one cycle latency; unmapped dwords read zero
	always_comb begin
		relative_temperature = anaSync2_reg ? hot_reg : (hot_reg - rdSync2_reg);
		rdData_next = ttp_pkg::WORD_RST;
		case (regAddr)
			ttp_pkg::TRIP_DW: rdData_next = {relative_temperature, aux0_reg, hot_reg, cat_reg};
			ttp_pkg::CAL_DW: rdData_next[{ttp_pkg::CAL_LANE, 3'b000} +: 8] = {calLock_reg, offset_reg};
			ttp_pkg::THR_DW: begin
				rdData_next[{ttp_pkg::THR_LANE, 3'b000} +: 8] = {thrEn_reg, 2'b00, thrZone_reg,
					thrHalt_reg, 2'b00, thrLock_reg};
				rdData_next[{ttp_pkg::FUSE_LANE, 3'b000} +: 8] = {sem_reg, fuseValue};
			end
			ttp_pkg::STAT_DW: rdData_next[{ttp_pkg::STAT_LANE, 3'b000} +: 16] = status_reg;
			ttp_pkg::AUXLOCK_DW: rdData_next = {auxLock_reg, 23'h000000, aux1_reg};
			default: rdData_next = ttp_pkg::WORD_RST;
		endcase
		if (!regRead) rdData_next = rdData_reg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData_reg <= ttp_pkg::WORD_RST;
			rdValid_reg <= 1'b0;
		end else begin
			rdData_reg <= rdData_next;
			rdValid_reg <= regRead;
		end
	end

	assign regRdata = rdData_reg;
	assign regRdValid = rdValid_reg;
	assign dacBankB = dac_reg;
	assign thermalTripOutN = tripN_reg;
	assign throttleRequest = throttle_reg;
	assign thermalEventPending = pending_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_relative_temperature_thermo: assert property (regRead && regAddr == ttp_pkg::TRIP_DW && !anaSync2_reg |=>
		regRdata[31:24] == 8'($past(hot_reg) - $past(rdSync2_reg))) else $error("relative_temperature wrong");
	a_relative_temperature_analog: assert property (regRead && regAddr == ttp_pkg::TRIP_DW && anaSync2_reg |=>
		regRdata[31:24] == $past(hot_reg)) else $error("analog relative_temperature wrong");
	a_aux0_locked: assert property (auxLock_reg |=> $stable(aux0_reg))
		else $error("aux0 changed while locked");
	a_hot_locked: assert property (calLock_reg |=> $stable(hot_reg) && $stable(cat_reg) &&
		$stable(offset_reg) && calLock_reg) else $error("locked field changed");
	a_dac_value: assert property (seeded_reg |=> dacBankB == ($past(directDacTest) ?
		signExt($past(offset_reg)) : 9'({1'b0, $past(rdSync2_reg)} + signExt($past(offset_reg)))))
		else $error("dac value wrong");
	a_master_off: assert property (!thrEn_reg |=> !throttleRequest && $stable(thermalTripOutN))
		else $error("action while disabled");
	a_trip_hold: assert property (!thermalTripOutN |=> !thermalTripOutN [*8])
		else $error("trip output released");
	a_sem_read: assert property (rdThr && !sem_reg && !regWrite |=> !regRdata[23] && sem_reg)
		else $error("semaphore read wrong");
	a_status_set: assert property (rise[3] |=> status_reg[ttp_pkg::ST_CAT_RISE])
		else $error("rise not recorded");
	a_status_sticky: assert property (status_reg[ttp_pkg::ST_HOT_FALL] && !wrStat |=>
		status_reg[ttp_pkg::ST_HOT_FALL]) else $error("status bit lost");
endmodule
`default_nettype wire

// ---- ttp_sensor_model.sv ----
// behavioural thermal sensor: thermometer counter, valid and mode pins
`timescale 1ns/10ps
`default_nettype none
module ttp_sensor_model (
	input wire logic clk, // core clock
	input wire logic [7:0] target, // temperature the die is heading for
	input wire logic slow, // ramp one count a cycle instead of jumping
	input wire logic convDone, // conversion has converged
	input wire logic analog, // run in analogue mode
	output logic [7:0] sensorReadingPin, // counter value
	output logic sensorValidPin, // counter is a temperature
	output logic analogModePin // analogue mode
);
	logic [7:0] count;
	initial begin
		count = 8'hff;
		sensorReadingPin = 8'h00;
		sensorValidPin = 1'b0;
		analogModePin = 1'b0;
	end
	always @(posedge clk) begin
		if (!slow || count == target)
			count <= target;
		else if (count < target)
			count <= count + 8'h01;
		else
			count <= count - 8'h01;
	end
	// unconverged counter is junk: keep it moving so nothing settles by luck
	always @(posedge clk) begin
		sensorValidPin <= convDone;
		analogModePin <= analog;
		sensorReadingPin <= convDone ? count : ~sensorReadingPin ^ 8'h5a;
	end
endmodule
`default_nettype wire

// ---- tb_thermal_trip_point_control.sv ----
// self-checking bench for the thermal trip point control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_thermal_trip_point_control;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] regAddr = 10'h000;
	logic [3:0] regByteEn = 4'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regWdata = 32'h0;
	logic [31:0] regRdata;
	logic regRdValid;
	logic [7:0] sensorReadingPin;
	logic sensorValidPin, analogModePin;
	logic directDacTest = 1'b0;
	logic [6:0] fuseValue = 7'h00;
	logic [8:0] dacBankB;
	logic thermalTripOutN, throttleRequest, thermalEventPending;
	logic [7:0] target = 8'h10;
	logic slow = 1'b0;
	logic convDone = 1'b1;
	logic analog = 1'b0;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];
	logic [31:0] eNow, mNow;
	logic [7:0] hot, cat, aux0, temp;
	logic [6:0] off;
	logic [11:0] keySeq[4];
	int mismatches = 0;
	int testsRun = 0;
	int seed = 47;

	always #5 clk = ~clk;

	ttp_control_top ttp_control_top_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr),
		.regByteEn(regByteEn), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
		.regRdata(regRdata), .regRdValid(regRdValid), .sensorReadingPin(sensorReadingPin),
		.sensorValidPin(sensorValidPin), .analogModePin(analogModePin),
		.directDacTest(directDacTest), .fuseValue(fuseValue), .dacBankB(dacBankB),
		.thermalTripOutN(thermalTripOutN), .throttleRequest(throttleRequest),
		.thermalEventPending(thermalEventPending));
	ttp_sensor_model ttp_sensor_model_inst (.clk(clk), .target(target), .slow(slow),
		.convDone(convDone), .analog(analog), .sensorReadingPin(sensorReadingPin),
		.sensorValidPin(sensorValidPin), .analogModePin(analogModePin));

	task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a[11:2];
		regByteEn <= be;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [3:0] be, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk);
		regAddr <= a[11:2];
		regByteEn <= be;
		regRead <= 1'b1;
		expQ.push_back(e & m);
		mskQ.push_back(m);
		@(posedge clk);
		regRead <= 1'b0;
	endtask
	task automatic wb(input logic [11:0] a, input logic [7:0] v);
		wr(a, 4'h1 << a[1:0], {24'h0, v} << (8 * a[1:0]));
	endtask
	task automatic rb(input logic [11:0] a, input logic [7:0] e);
		rd(a, 4'h1 << a[1:0], {24'h0, e} << (8 * a[1:0]), 32'hff << (8 * a[1:0]));
	endtask
	task automatic wst(input logic [15:0] v);
		wr(ttp_pkg::STAT_ADDR, 4'hc, {v, 16'h0000});
	endtask
	task automatic rst(input logic [15:0] e);
		rd(ttp_pkg::STAT_ADDR, 4'hc, {e, 16'h0000}, 32'hffff0000);
	endtask
	// slow ramp spans at most 255 counts, so 300 cycles always lands
	task automatic heat(input logic [7:0] t);
		@(posedge clk);
		target <= t;
		repeat (300) @(posedge clk);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d tests_run %0d", mismatches, testsRun);
		if (mismatches == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// read results arrive in request order; look mid-cycle when outputs have settled
	always @(negedge clk) begin
		if (regRdValid === 1'b1) begin
			`CHK(expQ.size() > 0, 1'b1)
			mNow = mskQ.pop_front();
			eNow = expQ.pop_front();
			`CHK(regRdata & mNow, eNow)
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up;
	end

	initial begin
		fuseValue = 7'($random(seed));
		keySeq = '{ttp_pkg::AUXLOCK_ADDR, ttp_pkg::KEYALT_ADDR, ttp_pkg::KEYALT_ADDR,
			ttp_pkg::AUXLOCK_ADDR};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rd(ttp_pkg::TRIP_ADDR, 4'hf, 32'hf0000000, 32'hffffffff);
		rb(ttp_pkg::THR_ADDR, 8'h00);
		// first valid reading sits above the zeroed settings: all four rising events
		rst(16'h001e);
		rb(ttp_pkg::CAL_ADDR, {1'b0, fuseValue});
		rb(ttp_pkg::FUSE_ADDR, {1'b0, fuseValue});
		rb(ttp_pkg::FUSE_ADDR, {1'b1, fuseValue});
		wb(ttp_pkg::FUSE_ADDR, 8'h00);
		rb(ttp_pkg::FUSE_ADDR, {1'b1, fuseValue});
		wb(ttp_pkg::FUSE_ADDR, 8'hff);
		rb(ttp_pkg::FUSE_ADDR, {1'b0, fuseValue});
		repeat (4) {cat, hot, aux0, temp} = $random(seed);
		for (int i = 0; i < 4; i++) begin
			{cat, hot, aux0, temp} = $random(seed);
			off = 7'($random(seed));
			slow <= 1'($random(seed));
			wr(ttp_pkg::TRIP_ADDR, 4'h7, {8'h00, aux0, hot, cat});
			wb(ttp_pkg::CAL_ADDR, {1'b0, off});
			heat(temp);
			rd(ttp_pkg::TRIP_ADDR, 4'hf, {8'(hot - temp), aux0, hot, cat}, 32'hffffffff);
			`CHK(dacBankB, {1'b0, temp} + {{2{off[6]}}, off})
			`CHK({thermalTripOutN, throttleRequest}, 2'b10)
			directDacTest <= 1'b1;
			analog <= 1'b1;
			repeat (6) @(posedge clk);
			`CHK(dacBankB, {{2{off[6]}}, off})
			rd(ttp_pkg::TRIP_ADDR, 4'h8, {hot, 24'h0}, 32'hff000000);
			directDacTest <= 1'b0;
			analog <= 1'b0;
		end
		wr(ttp_pkg::TRIP_ADDR, 4'h7, 32'h00406080);
		wb(ttp_pkg::AUXLOCK_ADDR, 8'h20);
		heat(8'h10);
		wst(16'hffff);
		rst(16'h0000);
		slow <= 1'b1;
		heat(8'hf0);
		rst(16'h001e);
		`CHK(thermalEventPending, 1'b1)
		heat(8'h10);
		rst(16'h03de);
		wst(16'h0000);
		rst(16'h03de);
		wst(16'h0010);
		rst(16'h03ce);
		wst(16'hfc21);
		rst(16'h03ce);
		wst(16'hffff);
		rst(16'h0000);
		repeat (4) @(posedge clk);
		`CHK(thermalEventPending, 1'b0)
		wb(ttp_pkg::CAL_ADDR, 8'h85);
		wr(ttp_pkg::TRIP_ADDR, 4'h7, 32'h00112233);
		rd(ttp_pkg::TRIP_ADDR, 4'h7, 32'h00116080, 32'h00ffffff);
		wb(ttp_pkg::CAL_ADDR, 8'h0a);
		rb(ttp_pkg::CAL_ADDR, 8'h85);
		wr(ttp_pkg::AUXLOCK_ADDR, 4'h8, 32'h80000000);
		wr(ttp_pkg::TRIP_ADDR, 4'h4, 32'h00440000);
		rd(ttp_pkg::TRIP_ADDR, 4'h4, 32'h00110000, 32'h00ff0000);
		foreach (keySeq[k]) wr(keySeq[k], 4'hf, ttp_pkg::UNLOCK_KEY);
		wr(ttp_pkg::TRIP_ADDR, 4'h4, 32'h00550000);
		rd(ttp_pkg::TRIP_ADDR, 4'h4, 32'h00550000, 32'h00ff0000);
		wb(ttp_pkg::THR_ADDR, 8'h99);
		wb(ttp_pkg::THR_ADDR, 8'h00);
		rb(ttp_pkg::THR_ADDR, 8'h99);
		heat(8'h70);
		`CHK({thermalTripOutN, throttleRequest}, 2'b11)
		heat(8'hf0);
		`CHK({thermalTripOutN, throttleRequest}, 2'b01)
		heat(8'h10);
		`CHK({thermalTripOutN, throttleRequest}, 2'b00)
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(thermalTripOutN, 1'b1)
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rb(ttp_pkg::CAL_ADDR, {1'b0, fuseValue});
		rb(ttp_pkg::THR_ADDR, 8'h00);
		repeat (3) @(posedge clk);
		wrap_up;
	end
endmodule
`default_nettype wire
